// ### pkg/pds_consts.vh
// Constants for the program dispatcher and channel scanner block.
// Assumes a 20 MHz clock; included by its bare name.
`ifndef PDS_CONSTS_VH
`define PDS_CONSTS_VH

// Clock rate in kHz
`define PDS_CLK_KHZ 20000
// Program codes with special handling
`define PDS_CODE_POLY 8'h06
`define PDS_CODE_COMBO 8'h1E
`define PDS_CODE_RANGE 8'h10
`define PDS_CODE_RMS 8'h14
`define PDS_CODE_AUTOSCAN 8'h36
// Exclusive group bounds
`define PDS_GRP2_LO 8'h0B
`define PDS_GRP2_HI 8'h0D
`define PDS_GRP3_LO 8'h0E
`define PDS_GRP3_HI 8'h10
`define PDS_GRP4_LO 8'h11
`define PDS_GRP4_HI 8'h14
// Highest valid math code and most stages in a chain
`define PDS_CODE_MATH_HI 8'h14
`define PDS_MAX_STAGES 3'h4
// Error code for a bad combination
`define PDS_ERR_COMBO 4'h2
// Calculation budgets in microseconds
`define PDS_RMS_US 300000
`define PDS_RANGE_US 7000
`define PDS_OTHER_US 1000
// Break-before-make gap in microseconds (within 1 to 3 ms)
`define PDS_GAP_US 2000
// Channel count
`define PDS_NUM_CH 20
`define PDS_CH_NONE 5'h1F

`endif

// ### verilog/pds_top.v
// Program combination checker/sequencer and scanner relay control.
// Assumes inputs from logic on clk, except meas_mode_pin (a panel level).
// Timing counts are parameters so that a bench can shorten them.
`timescale 1ns/1ps
`include "pds_consts.vh"

module pds_top #(
  parameter RMS_CYC = (`PDS_RMS_US * (`PDS_CLK_KHZ / 1000)),
  parameter RANGE_CYC = (`PDS_RANGE_US * (`PDS_CLK_KHZ / 1000)),
  parameter OTHER_CYC = (`PDS_OTHER_US * (`PDS_CLK_KHZ / 1000)),
  parameter GAP_CYC = (`PDS_GAP_US * (`PDS_CLK_KHZ / 1000)),
  parameter DWELL_CYC = 20000
) (
  // Clock, reset, enable
  input wire clk,
  input wire srst,
  input wire ce,
  // Combination entry: four codes, count of codes
  input wire combo_load,
  input wire [31:0] combo_codes,
  input wire [2:0] combo_count,
  // Program selection and mode
  input wire [7:0] prog_sel,
  input wire compute_start,
  input wire meas_mode_pin,
  // Stage handshake to arithmetic engine
  input wire stage_done,
  output reg [7:0] stage_code,
  output reg [1:0] stage_idx,
  output reg stage_run,
  output reg [31:0] stage_budget,
  output reg chain_done,
  // Error report
  output reg err_valid,
  output reg [3:0] err_code,
  // Scanner control
  input wire ch_select,
  input wire [4:0] ch_num,
  input wire ch_off,
  input wire [19:0] scan_mask,
  output reg [19:0] relay_close,
  output reg socket_connect,
  output reg scan_active
);

  // Two-flop synchroniser for the panel mode level
  reg meas_s1_reg;
  reg meas_s2_reg;
  always @(posedge clk) begin
    if (srst) begin
      meas_s1_reg <= 1'b0;
      meas_s2_reg <= 1'b0;
    end else if (ce) begin
      meas_s1_reg <= meas_mode_pin;
      meas_s2_reg <= meas_s1_reg;
    end
  end

  // Group number of a code: 0 bad, 1..4 groups, 5 polynomial
  // Polynomial gets its own number so that any chain holding it fails
  // Group 1 covers the linear and non-linear codes, without a limit
  function [2:0] grp_of;
    input [7:0] c;
    begin
      if (c == `PDS_CODE_POLY)
        grp_of = 3'd5;
      else if (c >= `PDS_GRP2_LO && c <= `PDS_GRP2_HI)
        grp_of = 3'd2;
      else if (c >= `PDS_GRP3_LO && c <= `PDS_GRP3_HI)
        grp_of = 3'd3;
      else if (c >= `PDS_GRP4_LO && c <= `PDS_GRP4_HI)
        grp_of = 3'd4;
      else if (c >= 8'h01 && c <= 8'h0A)
        grp_of = 3'd1;
      else
        grp_of = 3'd0;
    end
  endfunction

  // Calculation budget per code
  // Budget is a minimum wait per stage, counted in clock cycles
  function [31:0] budget_of;
    input [7:0] c;
    begin
      if (c == `PDS_CODE_RMS)
        budget_of = RMS_CYC;
      else if (c == `PDS_CODE_RANGE)
        budget_of = RANGE_CYC;
      else
        budget_of = OTHER_CYC;
    end
  endfunction

  // Combination validity check, combinational
  reg combo_ok;
  reg [3:0] grp_hits;
  reg [2:0] g;
  integer i;
  always @* begin
    combo_ok = 1'b1;
    grp_hits = 4'h0;
    g = 3'd0;
    // No code, or more than four, is never a chain
    if (combo_count == 3'd0 || combo_count > `PDS_MAX_STAGES)
      combo_ok = 1'b0;
    // Slots at or above the count are not judged
    for (i = 0; i < 4; i = i + 1) begin
      if (i < combo_count) begin
        g = grp_of(combo_codes[8*i +: 8]);
        if (g == 3'd0)
          combo_ok = 1'b0;
        else if (g == 3'd5)
          combo_ok = 1'b0;
        // Groups two to four may each appear once
        else if (g >= 3'd2) begin
          if (grp_hits[g[1:0]])
            combo_ok = 1'b0;
          grp_hits[g[1:0]] = 1'b1;
        end
      end
    end
  end

  // Sequencer states
  localparam S_IDLE = 3'b001;
  localparam S_RUN = 3'b010;
  localparam S_WAIT = 3'b100;
  // Latched chain, its length and the running budget
  reg [2:0] state_reg;
  reg [31:0] codes_reg;
  reg [2:0] count_reg;
  reg combo_valid_reg;
  reg [31:0] budget_cnt_reg;

  // Combination load, error report and stage sequencing
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= S_IDLE;
      codes_reg <= 32'h0000_0000;
      count_reg <= 3'h0;
      combo_valid_reg <= 1'b0;
      err_valid <= 1'b0;
      err_code <= 4'h0;
      stage_code <= 8'h00;
      stage_idx <= 2'h0;
      stage_run <= 1'b0;
      stage_budget <= 32'h0000_0000;
      chain_done <= 1'b0;
      budget_cnt_reg <= 32'h0000_0000;
    end else if (ce) begin
      // Report and stage strobes last one cycle
      err_valid <= 1'b0;
      chain_done <= 1'b0;
      stage_run <= 1'b0;
      // Loads are taken only while no chain runs
      if (combo_load && state_reg == S_IDLE) begin
        if (combo_ok) begin
          codes_reg <= combo_codes;
          count_reg <= combo_count;
          combo_valid_reg <= 1'b1;
        end else begin
          combo_valid_reg <= 1'b0;
          err_valid <= 1'b1;
          err_code <= `PDS_ERR_COMBO;
        end
      end
      case (state_reg)
        // Wait for compute on program 30
        S_IDLE: begin
          if (compute_start && prog_sel == `PDS_CODE_COMBO) begin
            if (combo_valid_reg) begin
              stage_idx <= 2'h0;
              state_reg <= S_RUN;
            end else begin
              // An unchecked or refused chain repeats the error
              err_valid <= 1'b1;
              err_code <= `PDS_ERR_COMBO;
            end
          end
        end
        // Issue current stage in listed order
        S_RUN: begin
          stage_code <= codes_reg[8*stage_idx +: 8];
          stage_budget <= budget_of(codes_reg[8*stage_idx +: 8]);
          budget_cnt_reg <= budget_of(codes_reg[8*stage_idx +: 8]);
          stage_run <= 1'b1;
          state_reg <= S_WAIT;
        end
        // Wait for result and budget to expire, then chain on
        S_WAIT: begin
          // Budget counts down while the engine works
          if (budget_cnt_reg != 32'h0000_0000)
            budget_cnt_reg <= budget_cnt_reg - 32'h0000_0001;
          if (stage_done && budget_cnt_reg <= 32'h0000_0001) begin
            // The last listed stage ends the chain
            if ({1'b0, stage_idx} + 3'h1 >= count_reg) begin
              chain_done <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              stage_idx <= stage_idx + 2'h1;
              state_reg <= S_RUN;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Scanner: target channel, gap timer, auto scan
  reg [4:0] target_reg;
  reg [4:0] cur_reg;
  reg [31:0] gap_cnt_reg;
  reg [31:0] dwell_cnt_reg;
  reg [4:0] nxt;
  integer k;
  integer idx; // Wrapped channel index

  // Next participating channel after current one
  // Walks down so that the nearest channel after the current one wins
  always @* begin
    nxt = cur_reg;
    idx = 0;
    for (k = 19; k >= 1; k = k - 1) begin
      idx = (cur_reg + k) % 20;
      if (scan_mask[idx])
        nxt = idx[4:0];
    end
  end

  // Relay sequencing with break before make
  // Only one relay closes at a time, so channels never short together
  always @(posedge clk) begin
    if (srst) begin
      relay_close <= 20'h0_0000;
      socket_connect <= 1'b1;
      scan_active <= 1'b0;
      target_reg <= `PDS_CH_NONE;
      cur_reg <= 5'h00;
      gap_cnt_reg <= 32'h0000_0000;
      dwell_cnt_reg <= 32'h0000_0000;
    end else if (ce) begin
      // Off, or measure mode during a scan, opens every relay and connects the socket
      if (ch_off || (scan_active && meas_s2_reg)) begin
        relay_close <= 20'h0_0000;
        socket_connect <= 1'b1;
        target_reg <= `PDS_CH_NONE;
        scan_active <= 1'b0;
        gap_cnt_reg <= 32'h0000_0000;
      end else if (compute_start && prog_sel == `PDS_CODE_AUTOSCAN &&
                   !scan_active && scan_mask != 20'h0_0000) begin
        // Program 54 with compute starts the cyclic scan
        scan_active <= 1'b1;
        relay_close <= 20'h0_0000;
        socket_connect <= 1'b0;
        cur_reg <= nxt;
        target_reg <= nxt;
        gap_cnt_reg <= GAP_CYC;
        dwell_cnt_reg <= DWELL_CYC;
      end else if (ch_select && !scan_active &&
                   ch_num < `PDS_NUM_CH && ch_num != target_reg) begin
        // Direct selection opens the old channel first
        relay_close <= 20'h0_0000;
        socket_connect <= 1'b0;
        target_reg <= ch_num;
        gap_cnt_reg <= GAP_CYC;
      end else if (gap_cnt_reg != 32'h0000_0000) begin
        // The new relay closes as the gap runs out
        gap_cnt_reg <= gap_cnt_reg - 32'h0000_0001;
        if (gap_cnt_reg == 32'h0000_0001)
          relay_close <= 20'h0_0001 << target_reg;
      end else if (scan_active) begin
        // Dwell on a channel, then step to the next
        if (dwell_cnt_reg > 32'h0000_0001)
          dwell_cnt_reg <= dwell_cnt_reg - 32'h0000_0001;
        else if (nxt != cur_reg) begin
          relay_close <= 20'h0_0000;
          cur_reg <= nxt;
          target_reg <= nxt;
          gap_cnt_reg <= GAP_CYC;
          dwell_cnt_reg <= DWELL_CYC;
        end
      end
    end
  end

endmodule // pds_top

// ### verification/pds_checker.sv
// Checker for pds_top port behaviour.
// Bound into pds_top; sees its ports only.
`timescale 1ns/1ps
module pds_checker #(
  parameter RMS_CYC = 8,
  parameter GAP_CYC = 4
) (
  // Watched ports
  input wire clk,
  input wire srst,
  input wire ce,
  input wire ch_off,
  input wire meas_mode_pin,
  input wire stage_run,
  input wire [7:0] stage_code,
  input wire [31:0] stage_budget,
  input wire err_valid,
  input wire [3:0] err_code,
  input wire [19:0] relay_close,
  input wire socket_connect,
  input wire scan_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire any_c = |relay_close; // Some relay closed
  reg [15:0] open_reg; // Cycles with every relay open
  // Count open cycles to measure the switching gap
  always @(posedge clk) begin
    if (srst || any_c) open_reg <= 16'h0000;
    // Saturates so that a long idle spell cannot wrap to a short gap
    else if (ce && open_reg != 16'hFFFF) open_reg <= open_reg + 16'h0001;
  end
  property p_one; $onehot0(relay_close); endproperty
  a_one: assert property (p_one) else $error("two relays");
  property p_sock; any_c |-> !socket_connect; endproperty
  a_sock: assert property (p_sock) else $error("socket on");
  property p_off; ce && ch_off |=> !any_c && socket_connect; endproperty
  a_off: assert property (p_off) else $error("off failed");
  property p_err; err_valid |-> err_code == 4'h2; endproperty
  a_err: assert property (p_err) else $error("bad err code");
  property p_gap; any_c && !$past(any_c) |-> open_reg >= GAP_CYC - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("short gap");
  property p_rms; stage_run && stage_code == 8'h14 |->
    stage_budget == RMS_CYC; endproperty
  a_rms: assert property (p_rms) else $error("rms budget");
  property p_rst; $fell(srst) |-> !any_c && socket_connect && !scan_active;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_stop; (ce && meas_mode_pin) [*4] |=> !scan_active; endproperty
  a_stop: assert property (p_stop) else $error("scan kept");
  c_err: cover property (err_valid);
  c_rms: cover property (stage_run && stage_code == 8'h14);
  c_scan: cover property (scan_active && any_c);
endmodule // pds_checker

bind pds_top pds_checker #(.RMS_CYC(RMS_CYC), .GAP_CYC(GAP_CYC)) chk_u (
  .clk(clk), .srst(srst), .ce(ce), .ch_off(ch_off),
  .meas_mode_pin(meas_mode_pin), .stage_run(stage_run),
  .stage_code(stage_code), .stage_budget(stage_budget),
  .err_valid(err_valid), .err_code(err_code), .relay_close(relay_close),
  .socket_connect(socket_connect), .scan_active(scan_active));

// ### verification/pds_eng_model.sv
// Arithmetic engine stand-in answering issued stages.
// Delay per stage is set by the bench.
`timescale 1ns/1ps
module pds_eng_model (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Stage handshake
  input wire stage_run,
  input wire [3:0] delay,
  output reg stage_done
);
  reg [3:0] cnt_reg; // Cycles since issue
  // Result ready after the delay, held until next stage
  always @(posedge clk) begin
    if (srst || stage_run) begin
      cnt_reg <= 4'h0;
      stage_done <= 1'b0;
    end else if (cnt_reg == delay) stage_done <= 1'b1;
    else cnt_reg <= cnt_reg + 4'h1;
  end
endmodule // pds_eng_model

// ### verification/tb_top.sv
// Self-checking bench for pds_top with an engine stand-in.
// Counts are shortened through parameters.
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg cl = 1'b0;
  reg [31:0] cc = 32'h0000_0000;
  reg [2:0] cn = 3'h0;
  reg [7:0] ps = 8'h00;
  reg cs = 1'b0;
  reg mm = 1'b0;
  reg sel = 1'b0;
  reg [4:0] chn = 5'h00;
  reg off = 1'b0;
  reg [19:0] msk = 20'h0_0000;
  reg [3:0] dly = 4'h1;
  reg en = 1'b1;
  wire sd, sr, cd, ev, sk, sa;
  wire [1:0] si;
  wire [7:0] sc;
  wire [31:0] sb;
  wire [3:0] ec;
  wire [19:0] rc;
  integer err_total = 0;
  integer checked = 0;
  integer cyc = 0;
  always #25 clk = ~clk;
  pds_top #(.RMS_CYC(8), .RANGE_CYC(4), .OTHER_CYC(2), .GAP_CYC(4),
    .DWELL_CYC(10)) dut_u (.clk(clk), .srst(srst), .ce(en),
    .combo_load(cl), .combo_codes(cc), .combo_count(cn), .prog_sel(ps),
    .compute_start(cs), .meas_mode_pin(mm), .stage_done(sd),
    .stage_code(sc), .stage_idx(si), .stage_run(sr), .stage_budget(sb),
    .chain_done(cd), .err_valid(ev), .err_code(ec), .ch_select(sel),
    .ch_num(chn), .ch_off(off), .scan_mask(msk), .relay_close(rc),
    .socket_connect(sk), .scan_active(sa));
  pds_eng_model eng_u (.clk(clk), .srst(srst), .stage_run(sr),
    .delay(dly), .stage_done(sd));
  task chk(input string what, input logic [31:0] seen, exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task tally_and_finish;
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  // Load a chain, codes low byte first; expect error pulse if bad
  task load(input [35:0] t);
    logic e;
    {e, cc, cn} = {1'b0, t[34:0]};
    // The host drops the leading point; only codes reach the block
    cl = 1'b1;
    tick(1);
    cl = 1'b0;
    e = ev;
    tick(1);
    e = e | ev;
    chk("err_valid", e, t[35]);
    if (t[35]) chk("err_code", ec, 4'h2);
  endtask
  // Good and bad combinations
  task t_combos;
    load({1'b1, 32'h0000_0106, 3'h2});
    load({1'b1, 32'h0000_0C0B, 3'h2});
    load({1'b1, 32'h0000_100E, 3'h2});
    load({1'b1, 32'h0000_1411, 3'h2});
    load({1'b1, 32'h0000_0015, 3'h1});
    load({1'b1, 32'h0403_0201, 3'h5});
    load({1'b1, 32'h0000_0001, 3'h0});
    ps = 8'h1E;
    cs = 1'b1;
    tick(1);
    cs = 1'b0;
    chk("run_err", ev, 1'b1);
    tick(1);
    chk("no_run", sr, 1'b0);
    load({1'b0, 32'h0403_0201, 3'h4});
    load({1'b0, 32'h1410_0D01, 3'h4});
  endtask
  // Chain runs stages in order with their budgets
  task t_chain;
    integer i;
    integer k;
    k = 0;
    load({1'b0, 32'h0014_1001, 3'h3});
    ps = 8'h1E;
    cs = 1'b1;
    tick(1);
    cs = 1'b0;
    for (i = 0; i < 200 && cd !== 1'b1; i = i + 1) begin
      if (sr === 1'b1) begin
        chk("code", sc, k == 0 ? 8'h01 : k == 1 ? 8'h10 : 8'h14);
        chk("budget", sb, k == 0 ? 32'h2 : k == 1 ? 32'h4 : 32'h8);
        chk("idx", si, k);
        k = k + 1;
      end
      tick(1);
    end
    chk("stages", k, 32'h3);
    chk("done", cd, 1'b1);
  endtask
  // Direct selection, break before make, then off
  task t_scan;
    integer i;
    for (i = 0; i < 2; i = i + 1) begin
      chn = i ? 5'h00 : 5'h13;
      sel = 1'b1;
      tick(1);
      sel = 1'b0;
      tick(1);
      chk("break", rc, 20'h0_0000);
      tick(1);
      chk("gap", rc, 20'h0_0000);
      tick(6);
      chk("make", rc, i ? 20'h0_0001 : 20'h8_0000);
      chk("socket", sk, 1'b0);
    end
    off = 1'b1;
    tick(1);
    off = 1'b0;
    chk("off", {sk, rc}, 21'h10_0000);
  endtask
  // Cyclic scan starts on compute and stops in measure mode
  task t_auto;
    msk = 20'h0_0006;
    ps = 8'h36;
    cs = 1'b1;
    tick(1);
    cs = 1'b0;
    tick(8);
    chk("scan", {sa, sk, |rc, |(rc & ~msk)}, 4'hA);
    tick(20);
    mm = 1'b1;
    tick(6);
    chk("stop", {sa, sk, rc}, 22'h10_0000);
    mm = 1'b0;
  endtask
  // Enable low freezes the gap; an out-of-range channel is ignored
  task t_freeze;
    chn = 5'h05;
    sel = 1'b1;
    tick(1);
    sel = 1'b0;
    en = 1'b0;
    tick(8);
    chk("frozen", rc, 20'h0_0000);
    en = 1'b1;
    tick(4);
    chk("thawed", rc, 20'h0_0020);
    chn = 5'h14;
    sel = 1'b1;
    tick(1);
    sel = 1'b0;
    tick(6);
    chk("ignored", rc, 20'h0_0020);
  endtask
  initial begin
    tick(4);
    srst = 1'b0;
    tick(1);
    chk("reset", {sa, sk, rc}, 22'h10_0000);
    t_combos;
    t_chain;
    dly = 4'hC;
    t_chain;
    t_scan;
    t_auto;
    t_freeze;
    tally_and_finish;
  end
endmodule // tb_top
